// file: inc/mdf_defines.svh
`ifndef MDF_DEFINES_SVH
`define MDF_DEFINES_SVH

// Clock and timer clock rates, in Hz.
`define MDF_CLK_HZ 100_000_000
`define MDF_CLK_PERIOD_NS 10
`define MDF_RATE0_HZ 10_000_000
`define MDF_RATE1_HZ 1_000_000
`define MDF_RATE2_HZ 100_000
`define MDF_RATE3_HZ 10_000
`define MDF_DIV0 (`MDF_CLK_HZ / `MDF_RATE0_HZ)
`define MDF_DIV1 (`MDF_CLK_HZ / `MDF_RATE1_HZ)
`define MDF_DIV2 (`MDF_CLK_HZ / `MDF_RATE2_HZ)
`define MDF_DIV3 (`MDF_CLK_HZ / `MDF_RATE3_HZ)

// Position-detect timer width and overflow.
`define MDF_TMR_W 12
`define MDF_TMR_MAX 12'hfff
`define MDF_PRE_W 14

// Lock retry step in ns; retry is (setting + 1) steps.
`define MDF_RETRY_UNIT_NS 1_000_000

// Field encodings.
`define MDF_STARTUP_PD 2'h2
`define MDF_OV_LATCHED 1'b0
`define MDF_OV_AUTO 1'b1
`define MDF_SPEED_I2C 2'h2
`define MDF_SPEED_FREQ 2'h3
`define MDF_PROFILE_DEF 2'h0

// Standby threshold scaling.
`define MDF_I2C_FULL_SCALE 24'h00_7fff
`define MDF_PCT_FULL 24'h00_0064
`define MDF_PCT_MIN 8'h01
`define MDF_FREQ_MIN_HZ 16'h0003

// Supply release margin and temperature codes.
`define MDF_OV_MARGIN 8'h0a
`define MDF_T_OTW 8'h8c
`define MDF_T_OTW_HYS 8'h0a
`define MDF_T_TSD 8'ha5
`define MDF_T_TSD_HYS 8'h14

`endif

// file: inc/mdf_pkg.sv
package mdf_pkg;

  typedef enum logic [2:0] {
    PD_IDLE,
    PD_WAIT,
    PD_RISE,
    PD_DECAY,
    PD_RETRY
  } mdf_pd_state_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_STANDBY,
    PWR_SLEEP
  } mdf_pwr_state_t;

  typedef logic [1:0] mdf_rate_t;

endpackage

// file: inc/mdf_timer_if.sv
`timescale 1ns/1ps
`include "mdf_defines.svh"

interface mdf_timer_if;
  logic start;
  logic abort;
  logic cond;
  logic busy;
  logic success;
  logic timeout;
  logic retry;
  logic [`MDF_TMR_W-1:0] count;
  mdf_pkg::mdf_rate_t rate;

  modport timer (input start, input abort, input cond,
                 output busy, output success, output timeout, output retry, output count, output rate);
  modport ctrl (output start, output abort, output cond,
                input busy, input success, input timeout, input retry, input count, input rate);
endinterface

// file: hw/mdf_pd_timer.sv
`timescale 1ns/1ps
`include "mdf_defines.svh"

module mdf_pd_timer #(
  parameter int DIV0 = `MDF_DIV0,
  parameter int DIV1 = `MDF_DIV1,
  parameter int DIV2 = `MDF_DIV2,
  parameter int DIV3 = `MDF_DIV3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Timer control
  mdf_timer_if.timer tmr
);
  import mdf_pkg::*;

  logic busy_reg;
  logic success_reg;
  logic timeout_reg;
  logic retry_reg;
  logic [`MDF_TMR_W-1:0] count_reg;
  mdf_rate_t rate_reg;
  logic [`MDF_PRE_W-1:0] pre_reg;
  logic [`MDF_PRE_W-1:0] pre_limit;
  logic tick;

  always_comb begin
    unique case (rate_reg)
      2'h0: pre_limit = `MDF_PRE_W'(DIV0 - 1);
      2'h1: pre_limit = `MDF_PRE_W'(DIV1 - 1);
      2'h2: pre_limit = `MDF_PRE_W'(DIV2 - 1);
      2'h3: pre_limit = `MDF_PRE_W'(DIV3 - 1);
    endcase
  end

  assign tick = busy_reg && (pre_reg == pre_limit);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_reg <= '0;
    end else if (!busy_reg || tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + `MDF_PRE_W'(1);
    end
  end

  // Each search opens at the fastest rate for full resolution.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_reg <= 1'b0;
      success_reg <= 1'b0;
      timeout_reg <= 1'b0;
      retry_reg <= 1'b0;
      count_reg <= '0;
      rate_reg <= 2'h0;
    end else begin
      success_reg <= 1'b0;
      timeout_reg <= 1'b0;
      retry_reg <= 1'b0;
      if (!busy_reg) begin
        if (tmr.start) begin
          busy_reg <= 1'b1;
          count_reg <= '0;
          rate_reg <= 2'h0;
        end
      end else if (tmr.abort) begin
        busy_reg <= 1'b0;
      end else if (tmr.cond) begin
        busy_reg <= 1'b0;
        success_reg <= 1'b1;
      end else if (tick) begin
        if (count_reg == `MDF_TMR_MAX) begin
          count_reg <= '0;
          if (rate_reg == 2'h3) begin
            busy_reg <= 1'b0;
            timeout_reg <= 1'b1;
          end else begin
            rate_reg <= rate_reg + 2'h1;
            retry_reg <= 1'b1;
          end
        end else begin
          count_reg <= count_reg + `MDF_TMR_W'(1);
        end
      end
    end
  end

  assign tmr.busy = busy_reg;
  assign tmr.success = success_reg;
  assign tmr.timeout = timeout_reg;
  assign tmr.retry = retry_reg;
  assign tmr.count = count_reg;
  assign tmr.rate = rate_reg;

endmodule // mdf_pd_timer

// file: hw/mdf_fault_power.sv
// Behaviour
// [R1] Latched overvoltage floats bridge till clear.
// [R2] Auto overvoltage clears below margin.
// [R3] Measuring rise timeout sets flag.
// [R4] Weak back-EMF sets measure flag.
// [R5] 12-bit pulse rise/decay timers.
// [R6] Rise rates 10 MHz, 1 MHz, 100 kHz, 10 kHz.
// [R7] All rates overflow: rise timeout.
// [R8] Same for decay: decay timeout.
// [R9] Timeouts reported when enabled.
// [R10] Early pulse: pulse-rate fault.
// [R11] Position fault: float, then retry.
// [R12] Reported warning: pin low, flags.
// [R13] Warning keeps driving; pin freed cool.
// [R14] Warning flag holds till clear and cool.
// [R15] Shutdown: FETs, pump off, pin low, flags.
// [R16] Shutdown recovers once cooled.
// [R17] Shutdown flag held till clear; always on.
// [R18] Idle: sleep if select 1, else standby.
// [R19] Sleep turns off supplies and I2C.
// [R20] Standby: supplies on till speed reaches threshold.
// [R21] I2C threshold max(1%, hys)*32767 or 0.
// [R22] Frequency threshold at least 3 Hz.
// [R23] Host clears once cause is gone.
// [R24] Auto faults release after retry time.
`timescale 1ns/1ps
`include "mdf_defines.svh"

module mdf_fault_power #(
  parameter int DIV3_CYCLES = `MDF_DIV3,
  parameter int RETRY_UNIT_CYCLES = `MDF_RETRY_UNIT_NS / `MDF_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Fault clear command
  input wire logic fault_clear_i,
  // Supply supervision
  input wire logic [7:0] supply_level_i,
  input wire logic [7:0] overvoltage_threshold_i,
  input wire logic overvoltage_response_i,
  // Parameter measurement
  input wire logic measure_rl_active_i,
  input wire logic measure_backemf_active_i,
  input wire logic measure_backemf_valid_i,
  input wire logic [11:0] measured_backemf_i,
  input wire logic [11:0] stationary_threshold_i,
  // Initial position detect
  input wire logic [1:0] startup_method_i,
  input wire logic position_detect_start_i,
  input wire logic position_detect_end_i,
  input wire logic position_pulse_cmd_i,
  input wire logic [11:0] phase_current_i,
  input wire logic [11:0] position_pulse_current_limit_i,
  input wire logic position_timeout_report_enable_i,
  input wire logic position_pulse_rate_report_enable_i,
  input wire logic [2:0] lock_retry_time_i,
  // Thermal
  input wire logic [7:0] die_temp_i,
  input wire logic thermal_warning_report_enable_i,
  // Power mode and speed command
  input wire logic low_power_select_i,
  input wire logic [1:0] speed_mode_i,
  input wire logic [1:0] profile_config_i,
  input wire logic [7:0] duty_hysteresis_i,
  input wire logic [14:0] digital_speed_i,
  input wire logic [15:0] speed_freq_i,
  input wire logic [15:0] input_max_freq_i,
  input wire logic speed_pin_idle_i,
  input wire logic speed_pin_wake_i,
  // Status flags
  output logic overvoltage_flag_o,
  output logic measure_position_timeout_flag_o,
  output logic measure_backemf_flag_o,
  output logic position_rise_timeout_flag_o,
  output logic position_decay_timeout_flag_o,
  output logic position_pulse_rate_flag_o,
  output logic thermal_warning_flag_o,
  output logic thermal_shutdown_flag_o,
  output logic temperature_event_flag_o,
  output logic driver_fault_flag_o,
  // Position-detect progress
  output logic position_pulse_on_o,
  output logic position_retry_o,
  output logic [11:0] position_rise_count_o,
  output logic [11:0] position_decay_count_o,
  // Power and bridge enables
  output logic bridge_hiz_o,
  output logic charge_pump_en_o,
  output logic sense_amp_en_o,
  output logic buck_en_o,
  output logic ldo_en_o,
  output logic i2c_en_o,
  output logic [1:0] power_state_o,
  // Open-drain fault pin
  output logic fault_out_n_o,
  output logic fault_out_n_oe_n_o
);
  import mdf_pkg::*;

  mdf_timer_if rise_if();
  mdf_timer_if decay_if();

  mdf_pd_timer #(
    .DIV0(`MDF_DIV0),
    .DIV1(`MDF_DIV1),
    .DIV2(`MDF_DIV2),
    .DIV3(DIV3_CYCLES)
  ) u_rise (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tmr(rise_if.timer)
  );

  mdf_pd_timer #(
    .DIV0(`MDF_DIV0),
    .DIV1(`MDF_DIV1),
    .DIV2(`MDF_DIV2),
    .DIV3(DIV3_CYCLES)
  ) u_decay (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tmr(decay_if.timer)
  );

  // Supply supervision.
  logic ov_latch_reg;
  logic ov_auto_reg;
  logic supply_over;
  logic supply_release;
  logic [8:0] release_level;

  assign supply_over = supply_level_i > overvoltage_threshold_i;
  assign release_level = {1'b0, overvoltage_threshold_i} - {1'b0, `MDF_OV_MARGIN};
  assign supply_release = !release_level[8] && ({1'b0, supply_level_i} < release_level);

  // A standing overvoltage beats a clear.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ov_latch_reg <= 1'b0;
    // [R1] latched overvoltage
    end else if (supply_over && overvoltage_response_i == `MDF_OV_LATCHED) begin
      ov_latch_reg <= 1'b1;
    end else if (fault_clear_i) begin
      ov_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ov_auto_reg <= 1'b0;
    // [R2] self-clearing overvoltage
    end else if (supply_over && overvoltage_response_i == `MDF_OV_AUTO) begin
      ov_auto_reg <= 1'b1;
    end else if (supply_release || overvoltage_response_i != `MDF_OV_AUTO) begin
      ov_auto_reg <= 1'b0;
    end
  end

  // Position-detect sequencing.
  mdf_pd_state_t pd_state_reg;
  logic [31:0] retry_cnt_reg;
  logic [31:0] retry_limit;
  logic rise_fault;
  logic decay_fault;
  logic rate_fault;
  logic pd_fault;
  logic pd_enabled;
  logic meas_pulse;

  assign pd_enabled = startup_method_i == `MDF_STARTUP_PD;
  assign retry_limit = 32'(RETRY_UNIT_CYCLES) * (32'(lock_retry_time_i) + 32'h0000_0001);
  assign meas_pulse = measure_rl_active_i && position_pulse_cmd_i && !rise_if.busy && !decay_if.busy;
  // [R9] timeout reporting gate
  assign rise_fault = pd_state_reg == PD_RISE && rise_if.timeout && position_timeout_report_enable_i;
  assign decay_fault = pd_state_reg == PD_DECAY && decay_if.timeout && position_timeout_report_enable_i;
  // [R10] pulse before decay
  assign rate_fault = position_pulse_rate_report_enable_i && position_pulse_cmd_i &&
                      (pd_state_reg == PD_RISE || pd_state_reg == PD_DECAY);
  assign pd_fault = rise_fault || decay_fault || rate_fault;

  // [R5] pulse timing
  assign rise_if.start = (pd_state_reg == PD_WAIT && position_pulse_cmd_i) || meas_pulse;
  assign decay_if.start = rise_if.success || (rise_if.timeout && !rise_fault && pd_state_reg == PD_RISE);
  // [R11] abort on fault
  assign rise_if.abort = pd_fault || position_detect_end_i;
  assign decay_if.abort = pd_fault || position_detect_end_i;
  // [R6] threshold reached
  assign rise_if.cond = phase_current_i >= position_pulse_current_limit_i;
  // [R8] decay reaches zero
  assign decay_if.cond = phase_current_i == 12'h000;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_state_reg <= PD_IDLE;
    end else if (position_detect_end_i || !pd_enabled) begin
      pd_state_reg <= PD_IDLE;
    end else begin
      unique case (pd_state_reg)
        PD_IDLE: begin
          if (position_detect_start_i) begin
            pd_state_reg <= PD_WAIT;
          end
        end
        PD_WAIT: begin
          if (position_pulse_cmd_i) begin
            pd_state_reg <= PD_RISE;
          end
        end
        PD_RISE: begin
          if (pd_fault) begin
            pd_state_reg <= PD_RETRY;
          end else if (decay_if.start) begin
            pd_state_reg <= PD_DECAY;
          end
        end
        PD_DECAY: begin
          if (pd_fault) begin
            pd_state_reg <= PD_RETRY;
          end else if (decay_if.success || decay_if.timeout) begin
            pd_state_reg <= PD_WAIT;
          end
        end
        // [R24] release after retry time
        PD_RETRY: begin
          if (retry_cnt_reg >= retry_limit - 32'h0000_0001) begin
            pd_state_reg <= PD_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      retry_cnt_reg <= '0;
    end else if (pd_state_reg != PD_RETRY) begin
      retry_cnt_reg <= '0;
    end else begin
      retry_cnt_reg <= retry_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      position_retry_o <= 1'b0;
      position_pulse_on_o <= 1'b0;
      position_rise_count_o <= '0;
      position_decay_count_o <= '0;
    end else begin
      // [R11] automatic retry strobe
      position_retry_o <= pd_state_reg == PD_RETRY && retry_cnt_reg >= retry_limit - 32'h0000_0001;
      position_pulse_on_o <= rise_if.busy;
      if (rise_if.success) begin
        position_rise_count_o <= rise_if.count;
      end
      if (decay_if.success) begin
        position_decay_count_o <= decay_if.count;
      end
    end
  end

  // Sticky flags: set beats clear.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      position_rise_timeout_flag_o <= 1'b0;
      position_decay_timeout_flag_o <= 1'b0;
      position_pulse_rate_flag_o <= 1'b0;
      measure_position_timeout_flag_o <= 1'b0;
      measure_backemf_flag_o <= 1'b0;
    end else begin
      // [R7] rise timeout flag
      position_rise_timeout_flag_o <= rise_fault || (position_rise_timeout_flag_o && !fault_clear_i);
      // [R8] decay timeout flag
      position_decay_timeout_flag_o <= decay_fault || (position_decay_timeout_flag_o && !fault_clear_i);
      position_pulse_rate_flag_o <= rate_fault || (position_pulse_rate_flag_o && !fault_clear_i);
      // [R3] measurement timeout
      measure_position_timeout_flag_o <= (measure_rl_active_i && rise_if.timeout) ||
                                         (measure_position_timeout_flag_o && !fault_clear_i);
      // [R4] weak back-EMF
      measure_backemf_flag_o <= (measure_backemf_active_i && measure_backemf_valid_i &&
                                 measured_backemf_i < stationary_threshold_i) ||
                                (measure_backemf_flag_o && !fault_clear_i);
    end
  end

  // Thermal supervision.
  logic warn_reg;
  logic tsd_reg;
  logic clear_pending_reg;
  logic warn_hot;
  logic warn_cool;
  logic tsd_hot;
  logic tsd_cool;

  assign warn_hot = die_temp_i > `MDF_T_OTW;
  assign warn_cool = die_temp_i < (`MDF_T_OTW - `MDF_T_OTW_HYS);
  assign tsd_hot = die_temp_i > `MDF_T_TSD;
  assign tsd_cool = die_temp_i < (`MDF_T_TSD - `MDF_T_TSD_HYS);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      warn_reg <= 1'b0;
    // [R12] warning detect
    end else if (warn_hot && thermal_warning_report_enable_i) begin
      warn_reg <= 1'b1;
    // [R13] warning release
    end else if (warn_cool || !thermal_warning_report_enable_i) begin
      warn_reg <= 1'b0;
    end
  end

  // No enable: shutdown cannot be disabled.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tsd_reg <= 1'b0;
    // [R15] shutdown detect
    end else if (tsd_hot) begin
      tsd_reg <= 1'b1;
    // [R16] shutdown recovery
    end else if (tsd_cool) begin
      tsd_reg <= 1'b0;
    end
  end

  // A clear given while warm with no warning active waits for the die to cool.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clear_pending_reg <= 1'b0;
    end else if (warn_reg) begin
      clear_pending_reg <= 1'b0;
    end else if (fault_clear_i) begin
      clear_pending_reg <= 1'b1;
    end else if (warn_cool) begin
      clear_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thermal_warning_flag_o <= 1'b0;
      thermal_shutdown_flag_o <= 1'b0;
      temperature_event_flag_o <= 1'b0;
      driver_fault_flag_o <= 1'b0;
    end else begin
      // [R14] warning flag hold
      thermal_warning_flag_o <= warn_reg ||
                                (thermal_warning_flag_o && !((fault_clear_i || clear_pending_reg) && warn_cool));
      // [R17] shutdown flag latch
      thermal_shutdown_flag_o <= tsd_reg || (thermal_shutdown_flag_o && !fault_clear_i);
      temperature_event_flag_o <= warn_reg || tsd_reg ||
                                  (temperature_event_flag_o && !(fault_clear_i && warn_cool));
      driver_fault_flag_o <= tsd_reg || (driver_fault_flag_o && !fault_clear_i);
    end
  end

  // Standby threshold and power mode.
  logic [7:0] hys_pct;
  logic [23:0] i2c_prod;
  logic [23:0] freq_prod;
  logic [14:0] i2c_thr;
  logic [15:0] freq_thr;
  logic idle;
  mdf_pwr_state_t pwr_state_reg;

  assign hys_pct = (duty_hysteresis_i < `MDF_PCT_MIN) ? `MDF_PCT_MIN : duty_hysteresis_i;
  assign i2c_prod = (24'(hys_pct) * `MDF_I2C_FULL_SCALE) / `MDF_PCT_FULL;
  assign freq_prod = (24'(hys_pct) * 24'(input_max_freq_i)) / `MDF_PCT_FULL;

  always_comb begin
    // [R21] I2C standby threshold
    i2c_thr = (profile_config_i == `MDF_PROFILE_DEF) ? i2c_prod[14:0] : 15'h0000;
    // [R22] frequency threshold floor
    if (profile_config_i != `MDF_PROFILE_DEF || freq_prod[15:0] < `MDF_FREQ_MIN_HZ) begin
      freq_thr = `MDF_FREQ_MIN_HZ;
    end else begin
      freq_thr = freq_prod[15:0];
    end
    unique case (speed_mode_i)
      `MDF_SPEED_I2C: idle = (digital_speed_i < i2c_thr) || (digital_speed_i == 15'h0000);
      `MDF_SPEED_FREQ: idle = speed_freq_i < freq_thr;
      default: idle = speed_pin_idle_i;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_state_reg <= PWR_STANDBY;
    end else begin
      unique case (pwr_state_reg)
        // [R18] idle mode choice
        PWR_ACTIVE: begin
          if (idle) begin
            pwr_state_reg <= low_power_select_i ? PWR_SLEEP : PWR_STANDBY;
          end
        end
        // [R20] wait for speed
        PWR_STANDBY: begin
          if (!idle) begin
            pwr_state_reg <= PWR_ACTIVE;
          end else if (low_power_select_i) begin
            pwr_state_reg <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (speed_pin_wake_i) begin
            pwr_state_reg <= PWR_ACTIVE;
          end
        end
        default: pwr_state_reg <= PWR_STANDBY;
      endcase
    end
  end

  // A warning alone never stops the bridge.
  logic sleeping;
  logic fault_low;

  assign sleeping = pwr_state_reg == PWR_SLEEP;
  assign fault_low = ov_latch_reg || ov_auto_reg || warn_reg || tsd_reg || pd_state_reg == PD_RETRY;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bridge_hiz_o <= 1'b1;
      charge_pump_en_o <= 1'b0;
      sense_amp_en_o <= 1'b0;
      buck_en_o <= 1'b0;
      ldo_en_o <= 1'b0;
      i2c_en_o <= 1'b0;
      power_state_o <= 2'h0;
      overvoltage_flag_o <= 1'b0;
      fault_out_n_oe_n_o <= 1'b1;
    end else begin
      // [R19] sleep shutdown
      bridge_hiz_o <= ov_latch_reg || ov_auto_reg || tsd_reg || pd_state_reg == PD_RETRY ||
                      pwr_state_reg != PWR_ACTIVE;
      charge_pump_en_o <= !tsd_reg && !sleeping;
      sense_amp_en_o <= !sleeping;
      buck_en_o <= !sleeping;
      ldo_en_o <= !sleeping;
      i2c_en_o <= !sleeping;
      power_state_o <= pwr_state_reg;
      overvoltage_flag_o <= ov_latch_reg || ov_auto_reg;
      fault_out_n_oe_n_o <= !fault_low;
    end
  end

  assign fault_out_n_o = 1'b0;

endmodule // mdf_fault_power

// file: tb/mdf_host_model.sv
`timescale 1ns/1ps
module mdf_host_model (
  // Clock and request
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic busy_i,
  // Clear command
  output logic clear_o
);
  initial clear_o = 1'b0;
  always @(posedge clk_i) begin
    clear_o <= req_i && !busy_i;
  end
endmodule // mdf_host_model

// file: tb/mdf_fault_power_checker.sv
`timescale 1ns/1ps
module mdf_fault_power_checker (
  // Clock, reset and causes
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic fault_clear_i,
  input wire logic [7:0] supply_level_i,
  input wire logic [7:0] overvoltage_threshold_i,
  input wire logic overvoltage_response_i,
  input wire logic [7:0] die_temp_i,
  // Watched outputs
  input wire logic overvoltage_flag_o,
  input wire logic thermal_shutdown_flag_o,
  input wire logic thermal_warning_flag_o,
  input wire logic bridge_hiz_o,
  input wire logic charge_pump_en_o,
  input wire logic i2c_en_o,
  input wire logic [1:0] power_state_o,
  input wire logic fault_out_n_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_ov_raise: assert property (supply_level_i > overvoltage_threshold_i |-> ##2 overvoltage_flag_o)
    else $error("ov not flagged");
  a_ov_float: assert property (overvoltage_flag_o |-> bridge_hiz_o && !fault_out_n_oe_n_o)
    else $error("ov bridge driven");
  a_ov_latch: assert property (overvoltage_flag_o && !overvoltage_response_i && !fault_clear_i
    && !$past(fault_clear_i) |=> overvoltage_flag_o) else $error("ov latch lost");
  a_ov_auto: assert property ((overvoltage_response_i && {1'b0, supply_level_i} + 9'h00a
    < {1'b0, overvoltage_threshold_i}) [*3] |-> !overvoltage_flag_o) else $error("ov auto stuck");
  a_tsd_act: assert property (die_temp_i > 8'ha5 |-> ##[1:4] (thermal_shutdown_flag_o && bridge_hiz_o
    && !charge_pump_en_o && !fault_out_n_oe_n_o)) else $error("tsd no action");
  a_tsd_latch: assert property (thermal_shutdown_flag_o && !fault_clear_i && !$past(fault_clear_i)
    |=> thermal_shutdown_flag_o) else $error("tsd latch lost");
  a_otw_hold: assert property (thermal_warning_flag_o && die_temp_i >= 8'h82 && $past(die_temp_i) >= 8'h82
    |=> thermal_warning_flag_o) else $error("otw dropped hot");
  a_sleep_off: assert property ((power_state_o == 2'h2) [*2]
    |-> !i2c_en_o && !charge_pump_en_o && bridge_hiz_o) else $error("sleep left on");
  c_ov_auto: cover property (overvoltage_flag_o && overvoltage_response_i);
  c_tsd: cover property (thermal_shutdown_flag_o);
  c_sleep: cover property (power_state_o == 2'h2);
endmodule // mdf_fault_power_checker
bind mdf_fault_power mdf_fault_power_checker chk_u (.*);

// file: tb/tb_mdf_fault_power.sv
`timescale 1ns/1ps
module tb_mdf_fault_power;
  logic clk_i, rstn_i, fault_clear_i, clr_req, overvoltage_response_i, measure_rl_active_i, speed_pin_idle_i;
  logic measure_backemf_active_i, measure_backemf_valid_i, position_detect_start_i, position_detect_end_i;
  logic position_pulse_cmd_i, position_timeout_report_enable_i, position_pulse_rate_report_enable_i;
  logic thermal_warning_report_enable_i, low_power_select_i, speed_pin_wake_i, overvoltage_flag_o;
  logic measure_position_timeout_flag_o, measure_backemf_flag_o, position_rise_timeout_flag_o;
  logic position_decay_timeout_flag_o, position_pulse_rate_flag_o, thermal_warning_flag_o, thermal_shutdown_flag_o;
  logic temperature_event_flag_o, driver_fault_flag_o, position_pulse_on_o, position_retry_o, bridge_hiz_o;
  logic charge_pump_en_o, sense_amp_en_o, buck_en_o, ldo_en_o, i2c_en_o, fault_out_n_o, fault_out_n_oe_n_o;
  logic [1:0] startup_method_i, speed_mode_i, profile_config_i, power_state_o;
  logic [2:0] lock_retry_time_i;
  logic [7:0] supply_level_i, overvoltage_threshold_i, die_temp_i, duty_hysteresis_i;
  logic [11:0] measured_backemf_i, stationary_threshold_i, phase_current_i, position_pulse_current_limit_i;
  logic [11:0] position_rise_count_o, position_decay_count_o;
  logic [14:0] digital_speed_i;
  logic [15:0] speed_freq_i, input_max_freq_i;
  int n_fail = 0, n_compared = 0, seed = 32'h0d59_4aba, n, thr;
  mdf_host_model host_u (.clk_i(clk_i), .req_i(clr_req), .busy_i(supply_level_i > overvoltage_threshold_i),
    .clear_o(fault_clear_i));
  mdf_fault_power #(.DIV3_CYCLES(20), .RETRY_UNIT_CYCLES(8)) dut_u (.*);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic w(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic clr();
    @(posedge clk_i) clr_req <= 1'b1;
    @(posedge clk_i) clr_req <= 1'b0;
    w(4);
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200_000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {clr_req, overvoltage_response_i, measure_rl_active_i, measure_backemf_valid_i, position_detect_start_i,
     position_detect_end_i, position_pulse_cmd_i, position_timeout_report_enable_i, low_power_select_i,
     speed_pin_idle_i, speed_pin_wake_i, rstn_i, profile_config_i, phase_current_i, speed_freq_i} = '0;
    {thermal_warning_report_enable_i, measure_backemf_active_i, position_pulse_rate_report_enable_i} = 3'h7;
    {supply_level_i, overvoltage_threshold_i, die_temp_i, duty_hysteresis_i} = 32'h80c0_4005;
    {startup_method_i, speed_mode_i, lock_retry_time_i} = 7'h53;
    {digital_speed_i, input_max_freq_i} = 31'h7fff_0028;
    {stationary_threshold_i, position_pulse_current_limit_i} = 24'h200_100;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_i) overvoltage_response_i <= r[0];
      @(posedge clk_i) supply_level_i <= 8'hc1;
      w(3);
      chk({overvoltage_flag_o, bridge_hiz_o, fault_out_n_oe_n_o}, 3'h6);
      @(posedge clk_i) supply_level_i <= r ? 8'hb6 : 8'h12;
      w(4);
      chk(overvoltage_flag_o, 1);
      @(posedge clk_i) supply_level_i <= 8'($unsigned($random(seed)) % 182);
      w(4);
      chk(overvoltage_flag_o, !r);
      clr();
      chk(overvoltage_flag_o, 0);
    end
    $display("overvoltage done");
    @(posedge clk_i) die_temp_i <= 8'h8d;
    w(4);
    chk({thermal_warning_flag_o, temperature_event_flag_o, fault_out_n_oe_n_o, bridge_hiz_o}, 4'hc);
    @(posedge clk_i) die_temp_i <= 8'h81;
    w(4);
    chk({thermal_warning_flag_o, fault_out_n_oe_n_o}, 2'h3);
    clr();
    chk(thermal_warning_flag_o, 0);
    @(posedge clk_i) thermal_warning_report_enable_i <= 1'b0;
    @(posedge clk_i) die_temp_i <= 8'ha6;
    w(4);
    chk({thermal_shutdown_flag_o, driver_fault_flag_o, bridge_hiz_o, charge_pump_en_o, fault_out_n_oe_n_o}, 5'h1c);
    @(posedge clk_i) die_temp_i <= 8'h90;
    w(4);
    chk({thermal_shutdown_flag_o, bridge_hiz_o, fault_out_n_oe_n_o}, 3'h5);
    clr();
    chk(thermal_shutdown_flag_o, 0);
    $display("thermal done");
    @(posedge clk_i) measured_backemf_i <= 12'h1ff;
    @(posedge clk_i) measure_backemf_valid_i <= 1'b1;
    @(posedge clk_i) measure_backemf_valid_i <= 1'b0;
    w(2);
    chk(measure_backemf_flag_o, 1);
    @(posedge clk_i) position_detect_start_i <= 1'b1;
    @(posedge clk_i) position_detect_start_i <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_i) position_pulse_cmd_i <= 1'b1;
      @(posedge clk_i) position_pulse_cmd_i <= 1'b0;
      w(2);
    end
    chk({position_pulse_rate_flag_o, bridge_hiz_o}, 2'h3);
    for (n = 2; n < 99 && position_retry_o !== 1'b1; n++) w(1);
    chk(n >= 31 && n <= 35, 1);
    w(2);
    chk(bridge_hiz_o, 0);
    $display("position done");
    thr = (duty_hysteresis_i > 1 ? duty_hysteresis_i : 1) * 32767 / 100;
    @(posedge clk_i) digital_speed_i <= 15'(thr - 1);
    w(4);
    chk({power_state_o, i2c_en_o, ldo_en_o, buck_en_o, charge_pump_en_o}, 6'h1f);
    @(posedge clk_i) digital_speed_i <= 15'(thr + $unsigned($random(seed)) % 1000);
    w(4);
    chk(power_state_o, 0);
    @(posedge clk_i) low_power_select_i <= 1'b1;
    @(posedge clk_i) digital_speed_i <= 15'h0000;
    w(4);
    chk({power_state_o, i2c_en_o, ldo_en_o, buck_en_o, charge_pump_en_o, sense_amp_en_o}, 7'h40);
    $display("power done");
    report_and_stop();
  end
endmodule // tb_mdf_fault_power
